/* common/afe_ctrl_defines.svh */
// Register offsets, field positions, reset values and divider constants
// for the analog front-end control block.
// Assumes an 8-bit register address space and 8-bit register data.
`ifndef AFE_CTRL_DEFINES_SVH
`define AFE_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AMP_MODE_ADDR       8'h90
`define AMP_CHANNEL_ADDR    8'h91
`define CHOPPER_CLK_ADDR    8'h92
`define PUMP_MODE_ADDR      8'h94
`define PUMP_CLK_ADDR       8'h96

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AMP_MODE_RESET      7'h0E
`define AMP_CHANNEL_RESET   3'h0
`define CHOPPER_CODE_RESET  3'h0
`define PUMP_CODE_RESET     4'h0
`define PUMP_CTRL_RESET     6'h00

// ----------------------------------------------------------------------
// Amplifier mode and channel fields
// ----------------------------------------------------------------------
`define AMP_ENABLE_BIT      0
`define GAIN_LSB            1
`define GAIN_MSB            3
`define LOW_FREQ_LSB        4
`define LOW_FREQ_MSB        5
`define BANDGAP_BIT         6
`define GAIN_LAST_VALID     3'h3
`define GAIN_UNITY          3'h7
`define CHANNEL_LAST_VALID  3'h3
`define CHANNEL_TEMP_SENSOR 3'h5

// ----------------------------------------------------------------------
// Pump mode fields
// ----------------------------------------------------------------------
`define PUMP_REG_BIT        0
`define PUMP_ON_BIT         1
`define PUMP_AUTO_BIT       2
`define REGULATOR_BIT       3
`define COMMON_MODE_BIT     4
`define EXCITATION_BIT      5
`define PUMP_STATUS_BIT     6

// ----------------------------------------------------------------------
// Clock dividers
// ----------------------------------------------------------------------
`define PUMP_PRESCALE_LOG2  2
`define PUMP_CODE_W         4
`define PUMP_CNT_W          17
`define CHOP_PRESCALE_LOG2  5
`define CHOP_CODE_W         3
`define CHOP_CNT_W          12

`endif

/* common/afe_ctrl_pkg.sv */
// Types shared by the analog front-end control block.
// Assumes the constants header is compiled alongside.
package afe_ctrl_pkg;

    typedef enum logic [1:0] {
        PUMP_OFF,
        PUMP_ON,
        PUMP_AUTO
    } pump_mode_type;

    typedef struct packed {
        logic [6:0]    amp_mode;
        logic [2:0]    channel;
        logic [2:0]    chop_code;
        logic [3:0]    pump_code;
        logic [5:0]    pump_ctrl;
        logic          supply_meta;
        logic          supply_sync;
        pump_mode_type mode;
        logic          pump_run;
        logic [7:0]    rdata;
    } main_state_type;

endpackage

/* verilog/clk_divider.sv */
// Glitch-free power-of-two clock divider for the analog clocks.
// Assumes the code input comes from a register on the same clock.
`timescale 1ns/1ps
`include "afe_ctrl_defines.svh"

module clk_divider
    import afe_ctrl_pkg::*;
#(
    parameter int BASE_LOG2 = 2,
    parameter int CODE_W    = 4,
    parameter int CNT_W     = 17
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic [CODE_W-1:0] code,
    output logic                   clk_out
);

    typedef struct packed {
        logic [CNT_W-1:0]  cnt;
        logic [CODE_W-1:0] code;
        logic              out;
    } div_state_type;

    div_state_type    s_ff;
    div_state_type    nxt_s;
    logic [CNT_W-1:0] mask;
    logic             wrap;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // A new code is taken only at the end of a full period, so the output
    // never shows a short high or low phase when software changes it.
    always_comb begin
        mask  = CNT_W'((33'h1 << (BASE_LOG2 + int'(s_ff.code))) - 33'h1);
        wrap  = (s_ff.cnt == mask);
        nxt_s = s_ff;
        if (wrap) begin
            nxt_s.cnt  = '0;
            nxt_s.code = code; // [RL20]
        end else begin
            nxt_s.cnt = s_ff.cnt + CNT_W'(1); // [RL1] [RL14]
        end
        nxt_s.out = |(nxt_s.cnt & ~(mask >> 1));
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_ff <= '0; // [RL20]
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign clk_out = s_ff.out;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [CNT_W:0]    gap_ff;
    logic [CODE_W-1:0] gap_code_ff;
    logic              seen_ff;
    logic              out_d_ff;
    logic              fell;

    assign fell = out_d_ff & ~s_ff.out;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            gap_ff      <= '0;
            gap_code_ff <= '0;
            seen_ff     <= 1'b0;
            out_d_ff    <= 1'b0;
        end else begin
            out_d_ff <= s_ff.out;
            if (fell) begin
                gap_ff      <= '0;
                gap_code_ff <= s_ff.code;
                seen_ff     <= 1'b1;
            end else begin
                gap_ff <= gap_ff + (CNT_W+1)'(1);
            end
        end
    end

    property p_period;
        @(posedge ref_clk) disable iff (!resetn)
        fell && seen_ff |->
            (int'(gap_ff) + 1) == (1 << (BASE_LOG2 + int'(gap_code_ff)));
    endproperty
    a_period: assert property (p_period) // [RL1] [RL14]
        else $error("divided clock period does not match its code");

    property p_edges;
        @(posedge ref_clk) disable iff (!resetn)
        $changed(s_ff.out) |->
            (s_ff.out ? (s_ff.cnt == ((mask >> 1) + CNT_W'(1)))
                      : (s_ff.cnt == '0));
    endproperty
    a_edges: assert property (p_edges) // [RL20]
        else $error("divided clock edge away from its phase point");

    property p_restart;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(resetn) |-> (s_ff.cnt == '0) && !s_ff.out;
    endproperty
    a_restart: assert property (p_restart) // [RL20]
        else $error("divider did not restart from zero after reset");

endmodule

/* verilog/code_hold.sv */
// Holds the last valid analog selection code while a reserved one is set.
// Assumes the accept input is decoded from the same register as code.
`timescale 1ns/1ps
`include "afe_ctrl_defines.svh"

module code_hold
    import afe_ctrl_pkg::*;
#(
    parameter logic [2:0] RESET_CODE = 3'h0
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [2:0] code,
    input  wire logic       accept,
    output logic [2:0]      held
);

    typedef struct packed {
        logic [2:0] held;
    } hold_state_type;

    hold_state_type s_ff;
    hold_state_type nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (accept) begin
            nxt_s.held = code; // [RL21]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_ff.held <= RESET_CODE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign held = s_ff.held;

    property p_keep;
        @(posedge ref_clk) disable iff (!resetn)
        !accept |=> $stable(held);
    endproperty
    a_keep: assert property (p_keep) // [RL21]
        else $error("analog selection moved on a reserved code");

endmodule

/* verilog/analog_frontend_ctrl_regs.sv */
// Register bank and clock dividers for the analog front end.
// Assumes a single-cycle register port on ref_clk and an asynchronous
// supply comparator level from the analog side.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "afe_ctrl_defines.svh"

// How it works
// [RL1] Pump clock is ref_clk/4/2^code.
// [RL2] Pump code: write-only low nibble, resets zero.
// [RL3] Software starts the pump with slow code.
// [RL4] Software targets 13-15 kHz, 2 kHz slow.
// [RL5] Software follows the analog power-up order.
// [RL6] Software speeds pump clock once stable.
// [RL7] Dry cells allow shorter pump delays.
// [RL8] Mode bit 0 enables the amplifier.
// [RL9] Bits 3..1 select gain; some reserved.
// [RL10] Unity gain may run with amplifier off.
// [RL11] Software always sets low-frequency field 11.
// [RL12] Mode bit 6 enables band-gap, set first.
// [RL13] Slow clock only allowed at unity gain.
// [RL14] Chopper clock is ref_clk/32/2^code.
// [RL15] Chopper code: write-only bits 2..0, reset zero.
// [RL16] Software targets about 2 kHz chopper clock.
// [RL17] Channel code routes the amplifier input.
// [RL18] Shorted inputs only for offset measurement.
// [RL19] Pump is off, always on, or automatic.
// [RL20] Dividers restart at reset, switch without glitches.
// [RL21] Reserved codes stored; outputs keep last valid.
module analog_frontend_ctrl_regs
    import afe_ctrl_pkg::*;
(
    input  wire logic    ref_clk,
    input  wire logic    resetn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic    wr_stb,
    input  wire logic    rd_stb,
    output logic [7:0]   rdata,
    input  wire logic    supply_low,
    output logic         amplifier_enable,
    output logic [2:0]   gain_select,
    output logic [1:0]   chopper_low_freq_sel,
    output logic         bandgap_enable,
    output logic [2:0]   channel_select,
    output logic         chopper_clk,
    output logic         pump_clk,
    output pump_mode_type pump_mode,
    output logic         pump_run,
    output logic         pump_regulator_enable,
    output logic         regulator_enable_flag,
    output logic         common_mode_enable_flag,
    output logic         excitation_enable_flag
);

    main_state_type s_ff;
    main_state_type nxt_s;
    logic           gain_ok;
    logic           chan_ok;

    // ------------------------------------------------------------------
    // Register access and pump mode decode
    // ------------------------------------------------------------------
    always_comb begin
        pump_mode_type mode_v;
        mode_v      = PUMP_OFF;
        nxt_s       = s_ff;
        nxt_s.rdata = 8'h00;
        if (wr_stb) begin
            case (addr)
                `AMP_MODE_ADDR:    nxt_s.amp_mode  = wdata[6:0]; // [RL8]
                `AMP_CHANNEL_ADDR: nxt_s.channel   = wdata[2:0]; // [RL17]
                `CHOPPER_CLK_ADDR: nxt_s.chop_code = wdata[2:0]; // [RL15]
                `PUMP_MODE_ADDR:   nxt_s.pump_ctrl = wdata[5:0]; // [RL19]
                `PUMP_CLK_ADDR:    nxt_s.pump_code = wdata[3:0]; // [RL2]
                default: ;
            endcase
        end
        // Write-only and unmapped offsets read back as zero.
        if (rd_stb) begin
            case (addr)
                `AMP_MODE_ADDR:    nxt_s.rdata = {1'b0, s_ff.amp_mode};
                `AMP_CHANNEL_ADDR: nxt_s.rdata = {5'h00, s_ff.channel};
                `PUMP_MODE_ADDR:
                    nxt_s.rdata = {1'b0, s_ff.pump_run, s_ff.pump_ctrl};
                default:           nxt_s.rdata = 8'h00; // [RL2] [RL15]
            endcase
        end
        // The always-on bit wins over auto; with neither the regulator
        // runs from the raw supply and the pump stays off.
        if (s_ff.pump_ctrl[`PUMP_REG_BIT]) begin
            if (s_ff.pump_ctrl[`PUMP_ON_BIT]) begin
                mode_v = PUMP_ON; // [RL19]
            end else if (s_ff.pump_ctrl[`PUMP_AUTO_BIT]) begin
                mode_v = PUMP_AUTO; // [RL19]
            end
        end
        nxt_s.mode        = mode_v;
        nxt_s.pump_run    = (mode_v == PUMP_ON) ||
                            ((mode_v == PUMP_AUTO) && s_ff.supply_sync);
        nxt_s.supply_meta = supply_low;
        nxt_s.supply_sync = s_ff.supply_meta;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_ff           <= '0;
            s_ff.amp_mode  <= `AMP_MODE_RESET;
            s_ff.channel   <= `AMP_CHANNEL_RESET;
            s_ff.chop_code <= `CHOPPER_CODE_RESET; // [RL15]
            s_ff.pump_code <= `PUMP_CODE_RESET; // [RL2]
            s_ff.pump_ctrl <= `PUMP_CTRL_RESET;
            s_ff.mode      <= PUMP_OFF;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // Analog selections
    // ------------------------------------------------------------------
    assign gain_ok = (s_ff.amp_mode[`GAIN_MSB:`GAIN_LSB] <=
                      `GAIN_LAST_VALID) ||
                     (s_ff.amp_mode[`GAIN_MSB:`GAIN_LSB] == `GAIN_UNITY);
    assign chan_ok = (s_ff.channel <= `CHANNEL_LAST_VALID) ||
                     (s_ff.channel == `CHANNEL_TEMP_SENSOR);

    code_hold #(
        .RESET_CODE (`GAIN_UNITY)
    ) u_gain_hold (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .code    (s_ff.amp_mode[`GAIN_MSB:`GAIN_LSB]),
        .accept  (gain_ok), // [RL9] [RL21]
        .held    (gain_select)
    );

    code_hold #(
        .RESET_CODE (`AMP_CHANNEL_RESET)
    ) u_chan_hold (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .code    (s_ff.channel),
        .accept  (chan_ok), // [RL17] [RL21]
        .held    (channel_select)
    );

    // ------------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------------
    clk_divider #(
        .BASE_LOG2 (`PUMP_PRESCALE_LOG2),
        .CODE_W    (`PUMP_CODE_W),
        .CNT_W     (`PUMP_CNT_W)
    ) u_pump_div (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .code    (s_ff.pump_code), // [RL1]
        .clk_out (pump_clk)
    );

    clk_divider #(
        .BASE_LOG2 (`CHOP_PRESCALE_LOG2),
        .CODE_W    (`CHOP_CODE_W),
        .CNT_W     (`CHOP_CNT_W)
    ) u_chop_div (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .code    (s_ff.chop_code), // [RL14]
        .clk_out (chopper_clk)
    );

    assign rdata                   = s_ff.rdata;
    assign amplifier_enable        = s_ff.amp_mode[`AMP_ENABLE_BIT]; // [RL8]
    assign chopper_low_freq_sel    =
        s_ff.amp_mode[`LOW_FREQ_MSB:`LOW_FREQ_LSB];
    assign bandgap_enable          = s_ff.amp_mode[`BANDGAP_BIT]; // [RL12]
    assign pump_mode               = s_ff.mode;
    assign pump_run                = s_ff.pump_run;
    assign pump_regulator_enable   = s_ff.pump_ctrl[`PUMP_REG_BIT];
    assign regulator_enable_flag   = s_ff.pump_ctrl[`REGULATOR_BIT];
    assign common_mode_enable_flag = s_ff.pump_ctrl[`COMMON_MODE_BIT];
    assign excitation_enable_flag  = s_ff.pump_ctrl[`EXCITATION_BIT];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_amp_write;
        wr_stb && addr == `AMP_MODE_ADDR;
    endsequence

    property p_pump_code;
        @(posedge ref_clk) disable iff (!resetn)
        wr_stb && addr == `PUMP_CLK_ADDR
            |=> s_ff.pump_code == $past(wdata[3:0]);
    endproperty
    a_pump_code: assert property (p_pump_code) // [RL2]
        else $error("pump clock code not stored");

    property p_write_only;
        @(posedge ref_clk) disable iff (!resetn)
        rd_stb && (addr == `PUMP_CLK_ADDR || addr == `CHOPPER_CLK_ADDR)
            |=> rdata == 8'h00;
    endproperty
    a_write_only: assert property (p_write_only) // [RL15]
        else $error("write-only register did not read as zero");

    property p_amp_enable;
        @(posedge ref_clk) disable iff (!resetn)
        s_amp_write |=> amplifier_enable == $past(wdata[0]);
    endproperty
    a_amp_enable: assert property (p_amp_enable) // [RL8]
        else $error("amplifier enable does not follow its bit");

    property p_bandgap;
        @(posedge ref_clk) disable iff (!resetn)
        s_amp_write |=> bandgap_enable == $past(wdata[6]);
    endproperty
    a_bandgap: assert property (p_bandgap) // [RL12]
        else $error("band-gap enable does not follow its bit");

    property p_gain;
        @(posedge ref_clk) disable iff (!resetn)
        s_amp_write ##1 gain_ok |=> gain_select == $past(wdata[3:1], 2);
    endproperty
    a_gain: assert property (p_gain) // [RL9]
        else $error("valid gain code not applied in two cycles");

    property p_channel;
        @(posedge ref_clk) disable iff (!resetn)
        wr_stb && addr == `AMP_CHANNEL_ADDR ##1 chan_ok
            |=> channel_select == $past(wdata[2:0], 2);
    endproperty
    a_channel: assert property (p_channel) // [RL17]
        else $error("valid channel code not applied in two cycles");

    property p_chop_code;
        @(posedge ref_clk) disable iff (!resetn)
        wr_stb && addr == `CHOPPER_CLK_ADDR
            |=> s_ff.chop_code == $past(wdata[2:0]);
    endproperty
    a_chop_code: assert property (p_chop_code) // [RL15]
        else $error("chopper clock code not stored");

    property p_pump_on;
        @(posedge ref_clk) disable iff (!resetn)
        wr_stb && addr == `PUMP_MODE_ADDR && wdata[1:0] == 2'h3
            |=> ##1 pump_mode == PUMP_ON && pump_run;
    endproperty
    a_pump_on: assert property (p_pump_on) // [RL19]
        else $error("always-on pump mode not reached in two cycles");

    property p_pump_off;
        @(posedge ref_clk) disable iff (!resetn)
        !s_ff.pump_ctrl[0] |=> pump_mode == PUMP_OFF && !pump_run;
    endproperty
    a_pump_off: assert property (p_pump_off) // [RL19]
        else $error("pump running with regulator disabled");

endmodule

/* bench/analog_pump_model.sv */
// Behavioural model of the analog side: the supply comparator and the
// band-gap check on pump use. Assumes the bench commands the supply level.
`timescale 1ns/1ps

module analog_pump_model (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic low_cmd,
    input  wire logic pump_run,
    input  wire logic bandgap_enable,
    output logic      supply_low,
    output logic      misuse_ff
);
    // The comparator moves a little after the edge, as a free analog level
    // would, so the design's synchroniser sees a truly unaligned change.
    always @(posedge ref_clk) begin
        supply_low <= #3 low_cmd;
        if (!resetn) begin
            misuse_ff <= 1'h0;
        end else if (pump_run && !bandgap_enable) begin
            misuse_ff <= 1'h1;
        end
    end
endmodule

/* bench/tb_analog_frontend_ctrl_regs.sv */
// Self-checking bench for the analog front-end control registers.
// Assumes the package and constants header are compiled before it.
`timescale 1ns/1ps
`include "afe_ctrl_defines.svh"

module tb_analog_frontend_ctrl_regs
    import afe_ctrl_pkg::*;
;
    logic          ref_clk, resetn, wr_stb, rd_stb, low_cmd;
    logic [7:0]    addr, wdata, rdata;
    logic          supply_low, misuse_ff, amplifier_enable, bandgap_enable;
    logic [2:0]    gain_select, channel_select;
    logic [1:0]    chopper_low_freq_sel;
    logic          chopper_clk, pump_clk, pump_run, pump_regulator_enable;
    logic          regulator_enable_flag, common_mode_enable_flag;
    logic          excitation_enable_flag;
    pump_mode_type pump_mode;
    int            fails, n_compared;

    // ------------------------------------------------------------------
    // Design and analog partner
    // ------------------------------------------------------------------
    analog_frontend_ctrl_regs analog_frontend_ctrl_regs_inst (
        .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .supply_low(supply_low), .amplifier_enable(amplifier_enable),
        .gain_select(gain_select),
        .chopper_low_freq_sel(chopper_low_freq_sel),
        .bandgap_enable(bandgap_enable), .channel_select(channel_select),
        .chopper_clk(chopper_clk), .pump_clk(pump_clk),
        .pump_mode(pump_mode), .pump_run(pump_run),
        .pump_regulator_enable(pump_regulator_enable),
        .regulator_enable_flag(regulator_enable_flag),
        .common_mode_enable_flag(common_mode_enable_flag),
        .excitation_enable_flag(excitation_enable_flag));

    analog_pump_model analog_pump_model_inst (
        .ref_clk(ref_clk), .resetn(resetn), .low_cmd(low_cmd),
        .pump_run(pump_run), .bandgap_enable(bandgap_enable),
        .supply_low(supply_low), .misuse_ff(misuse_ff));

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Bus, compare and wait tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic compare(input logic [7:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic compare_count(input int got, exp, input string what);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("mismatch at %0t: %s got %0d want %0d", $time, what,
                     got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, d);
        @(posedge ref_clk);
        wr_stb <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_stb <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_stb <= 1'h1;
        addr <= a;
        @(posedge ref_clk);
        rd_stb <= 1'h0;
        #1 d = rdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_run(input logic exp);
        for (int n = 0; n < 8 && pump_run !== exp; n++) begin
            @(posedge ref_clk);
            #1;
        end
        compare(8'(pump_run), 8'(exp), "pump run");
        if (pump_run !== exp) final_report();
    endtask

    // Measures one whole period between the second and third rise, so a
    // period still running on the old code is never counted.
    task automatic clk_period(input bit sel, output int per);
        logic prev, cur;
        int   rises, t0;
        prev = sel ? chopper_clk : pump_clk;
        rises = 0;
        per = 0;
        t0 = 0;
        for (int n = 0; n < 40000 && rises < 3; n++) begin
            @(posedge ref_clk);
            #1 cur = sel ? chopper_clk : pump_clk;
            if (cur && !prev) begin
                rises++;
                if (rises == 2) t0 = n;
                if (rises == 3) per = n - t0;
            end
            prev = cur;
        end
        if (rises < 3) begin
            fails++;
            $display("mismatch at %0t: divided clock stalled", $time);
            final_report();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic check_reset();
        logic [7:0] d;
        reg_read(`AMP_MODE_ADDR, d);
        compare(d, 8'h0E, "amp mode reset");
        reg_read(`AMP_CHANNEL_ADDR, d);
        compare(d, 8'h00, "channel reset");
        reg_read(`CHOPPER_CLK_ADDR, d);
        compare(d, 8'h00, "chopper code read");
        reg_read(`PUMP_CLK_ADDR, d);
        compare(d, 8'h00, "pump code read");
        reg_read(8'h93, d);
        compare(d, 8'h00, "unmapped read");
        compare(8'(gain_select), 8'h07, "gain reset");
        compare(8'(amplifier_enable), 8'h00, "enable reset");
        compare(8'(bandgap_enable), 8'h00, "band-gap reset");
        compare(8'(pump_mode), 8'h00, "pump mode reset");
    endtask

    task automatic check_amp_mode();
        logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
        logic [2:0] held;
        logic [7:0] d, r;
        held = 3'h7;
        for (int i = 0; i < 7; i++) begin
            d = {2'h1, 2'h3, codes[i], 1'(i)};
            if (codes[i] <= 3'h3 || codes[i] == 3'h7) held = codes[i];
            reg_write(`AMP_MODE_ADDR, d);
            settle();
            compare(8'(amplifier_enable), 8'(i % 2), "enable");
            compare(8'(gain_select), 8'(held), "gain");
            compare(8'(chopper_low_freq_sel), 8'h03, "low freq");
            compare(8'(bandgap_enable), 8'h01, "band-gap");
            reg_read(`AMP_MODE_ADDR, r);
            compare(r, d, "amp mode readback");
        end
        reg_write(`AMP_MODE_ADDR, 8'h0E);
        settle();
        compare(8'(bandgap_enable), 8'h00, "band-gap off");
        compare(8'(chopper_low_freq_sel), 8'h00, "low freq off");
    endtask

    task automatic check_channel();
        logic [2:0] held;
        logic [7:0] r;
        held = 3'h0;
        for (int c = 0; c < 8; c++) begin
            if (c <= 3 || c == 5) held = 3'(c);
            reg_write(`AMP_CHANNEL_ADDR, 8'(c));
            settle();
            compare(8'(channel_select), 8'(held), "channel");
            reg_read(`AMP_CHANNEL_ADDR, r);
            compare(r, 8'(c), "channel readback");
        end
    endtask

    task automatic check_power_up();
        logic [7:0] r;
        reg_write(`AMP_MODE_ADDR, 8'h40);
        reg_write(`PUMP_CLK_ADDR, 8'h0B);
        reg_write(`PUMP_MODE_ADDR, 8'h06);
        settle();
        compare(8'(pump_mode), 8'(PUMP_OFF), "pump off");
        reg_write(`PUMP_MODE_ADDR, 8'h05);
        settle();
        compare(8'(pump_mode), 8'(PUMP_AUTO), "pump auto");
        wait_run(1'h0);
        low_cmd <= 1'h1;
        wait_run(1'h1);
        low_cmd <= 1'h0;
        wait_run(1'h0);
        reg_write(`PUMP_MODE_ADDR, 8'h07);
        settle();
        compare(8'(pump_mode), 8'(PUMP_ON), "pump on");
        wait_run(1'h1);
        reg_write(`PUMP_CLK_ADDR, 8'h04);
        reg_write(`PUMP_MODE_ADDR, 8'h17);
        reg_write(`PUMP_MODE_ADDR, 8'h1F);
        reg_write(`PUMP_MODE_ADDR, 8'h3F);
        settle();
        compare({4'h0, excitation_enable_flag, common_mode_enable_flag,
                 regulator_enable_flag, pump_regulator_enable}, 8'h0F,
                "supply flags");
        reg_read(`PUMP_MODE_ADDR, r);
        compare(r, 8'h7F, "pump mode readback");
        reg_write(`PUMP_MODE_ADDR, 8'h00);
        settle();
        compare(8'(pump_mode), 8'(PUMP_OFF), "pump off again");
        wait_run(1'h0);
    endtask

    task automatic check_dividers();
        logic [3:0] codes [3] = '{4'hB, 4'h4, 4'h1};
        logic [7:0] r;
        int         per;
        for (int i = 0; i < 3; i++) begin
            reg_write(`PUMP_CLK_ADDR, 8'(codes[i]));
            clk_period(1'h0, per);
            compare_count(per, 4 << codes[i], "pump period");
        end
        reg_read(`PUMP_CLK_ADDR, r);
        compare(r, 8'h00, "pump code read");
        for (int c = 7; c >= 0; c--) begin
            reg_write(`CHOPPER_CLK_ADDR, 8'(c));
            clk_period(1'h1, per);
            compare_count(per, 32 << c, "chopper period");
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int per;
        fails = 0;
        n_compared = 0;
        resetn = 1'h0;
        wr_stb = 1'h0;
        rd_stb = 1'h0;
        addr = 8'h00;
        wdata = 8'h00;
        low_cmd = 1'h0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'h1;
        check_reset();
        check_amp_mode();
        check_channel();
        check_power_up();
        check_dividers();
        compare(8'(misuse_ff), 8'h00, "pump without band-gap");
        // A reset in mid-run must bring the pump code back to zero.
        @(posedge ref_clk);
        resetn <= 1'h0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'h1;
        check_reset();
        clk_period(1'h0, per);
        compare_count(per, 4, "pump period after reset");
        final_report();
    end
endmodule
